// ---- verilog/wlc_pkg.sv ----
// Constants of the wake-up and low-power pin control block.
// Assumes a 32-bit register port with byte offsets.
`default_nettype none
package wlc_pkg;
    localparam int NUM_WAKE = 5;
    localparam int NUM_LP = 3;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFS_WAKE_LEVEL = 8'h00;
    localparam logic [7:0] OFS_WAKE_EN = 8'h04;
    localparam logic [7:0] OFS_XTAL_CFG = 8'h08;
    localparam logic [7:0] OFS_LP_DIR = 8'h0c;
    localparam logic [7:0] OFS_LP_OUT = 8'h10;
    localparam logic [7:0] OFS_LP_DRIVE = 8'h14;
    localparam logic [7:0] OFS_LP_PULL = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
    localparam logic [7:0] OFS_CLK_CTRL = 8'h28;
    localparam logic [7:0] OFS_CLK_STATUS = 8'h2c;
    // Values after reset
    localparam logic [4:0] RST_WAKE_LEVEL = 5'h00;
    localparam logic [4:0] RST_WAKE_EN = 5'h07;
    localparam logic RST_FAST_XTAL = 1'b0;
    localparam logic [2:0] RST_LP_DIR = 3'h7;
    localparam logic [2:0] RST_LP_OUT = 3'h0;
    localparam logic [2:0] RST_LP_DRIVE = 3'h0;
    localparam logic [2:0] RST_LP_PULL = 3'h0;
    localparam logic [1:0] RST_CLK_CTRL = 2'h0;
    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_XO_READY = 1;
    localparam int IRQ_XO_LOST = 2;
    // Clock control and status bits
    localparam int CLK_XO_REQ = 0;
    localparam int CLK_LF_XTAL = 1;
    localparam int CST_HF_XO = 0;
    localparam int CST_LF_XTAL = 1;
    localparam int CST_LP_MODE = 2;
    localparam int CST_WAKE_REQ = 3;
    localparam int CST_XO_START = 4;
endpackage : wlc_pkg
`default_nettype wire

// ---- verilog/wlc_cfg_if.sv ----
// Carrier between the register bank and its pin submodules.
// Assumes all parties sit on mclk.
`default_nettype none
interface wlc_cfg_if #(
    parameter int NW = 5,
    parameter int NL = 3
);
    logic lp_mode;
    logic [NW-1:0] wake_level;
    logic [NW-1:0] wake_en;
    logic [NW-1:0] wake_pins;
    logic [NW-1:0] wake_hit;
    logic wake_req;
    logic [NL-1:0] lp_dir;
    logic [NL-1:0] lp_out;
    logic [NL-1:0] pin_o;
    logic [NL-1:0] pin_oe;
    modport regs (output lp_mode, wake_level, wake_en, wake_pins, lp_dir, lp_out,
                  input wake_hit, wake_req, pin_o, pin_oe);
    modport wake (input lp_mode, wake_level, wake_en, wake_pins,
                  output wake_hit, wake_req);
    modport pad (input lp_mode, wake_en, lp_dir, lp_out, output pin_o, pin_oe);
endinterface : wlc_cfg_if
`default_nettype wire

// ---- verilog/wlc_wake_detect.sv ----
// Per-pin wake level match and combined wake request.
// Assumes wake pins are already synchronous to mclk.
`default_nettype none
module wlc_wake_detect #(
    parameter int NW = 5
) (
    // Configuration and pins
    wlc_cfg_if.wake cfg
);
    if (NW < 1 || NW > 32)
    begin : g_chk
        $error("wlc_wake_detect: NW out of range");
    end
    for (genvar i = 0; i < NW; i++)
    begin : g_pin
        // Level bit 1 matches high, 0 matches low
        assign cfg.wake_hit[i] = cfg.wake_en[i] &
            (cfg.wake_pins[i] == cfg.wake_level[i]);
    end
    assign cfg.wake_req = cfg.lp_mode & (|cfg.wake_hit);
endmodule : wlc_wake_detect
`default_nettype wire

// ---- verilog/wlc_lp_pad.sv ----
// Output value and enable of the low-power pins.
// Assumes the pad ring muxes these in only during sleep or standby.
`default_nettype none
module wlc_lp_pad #(
    parameter int NL = 3
) (
    // Configuration and pad controls
    wlc_cfg_if.pad cfg
);
    if (NL < 1 || NL > 5)
    begin : g_chk
        $error("wlc_lp_pad: NL out of range");
    end
    for (genvar i = 0; i < NL; i++)
    begin : g_pin
        // Direction 0 is output; a wake source never drives
        assign cfg.pin_oe[i] = cfg.lp_mode & ~cfg.lp_dir[i]
            & ~cfg.wake_en[i];
        assign cfg.pin_o[i] = cfg.pin_oe[i] & cfg.lp_out[i];
    end
endmodule : wlc_lp_pad
`default_nettype wire

// ---- verilog/wlc_ctrl.sv ----
// Register bank for wake-up pins, crystal indication, low-power pins
// and clock source selection.
// Assumes a single-cycle strobe register port on mclk and pins
// already synchronous to mclk.
`default_nettype none
module wlc_ctrl #(
    parameter int NW = 5,
    parameter int NL = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [wlc_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Power state
    input wire logic lp_mode,
    output logic wake_req,
    // Wake pins
    input wire logic [NW-1:0] wake_pins,
    // Low-power pins
    output logic [NL-1:0] lp_pin_o,
    output logic [NL-1:0] lp_pin_oe,
    output logic [NL-1:0] lp_drive_hi,
    output logic [NL-1:0] lp_pull_en,
    // Clock sources
    input wire logic xo_ready,
    input wire logic lf_xtal_ok,
    output logic xo_enable,
    output logic hf_sel_xo,
    output logic lf_sel_xtal,
    output logic fast_crystal_flag,
    // Interrupt
    output logic irq
);
    if (NW != wlc_pkg::NUM_WAKE || NL != wlc_pkg::NUM_LP)
    begin : g_chk
        $error("wlc_ctrl: pin counts must match the register layout");
    end

    typedef enum {
        HF_RING,
        HF_START,
        HF_XO
    } wlc_hf_e;

    wlc_cfg_if #(.NW(NW), .NL(NL)) cfg ();

    // Configuration registers
    logic [NW-1:0] wake_level_q;
    logic [NW-1:0] wake_level_d;
    logic [NW-1:0] wake_src_q;
    logic [NW-1:0] wake_src_d;
    logic fast_xtal_q;
    logic fast_xtal_d;
    logic [NL-1:0] lp_dir_q;
    logic [NL-1:0] lp_dir_d;
    logic [NL-1:0] lp_out_q;
    logic [NL-1:0] lp_out_d;
    logic [NL-1:0] lp_drive_q;
    logic [NL-1:0] lp_drive_d;
    logic [NL-1:0] lp_pull_q;
    logic [NL-1:0] lp_pull_d;
    logic [1:0] clk_ctrl_q;
    logic [1:0] clk_ctrl_d;
    // Interrupt state
    logic [wlc_pkg::IRQ_W-1:0] irq_stat_q;
    logic [wlc_pkg::IRQ_W-1:0] irq_stat_d;
    logic [wlc_pkg::IRQ_W-1:0] irq_en_q;
    logic [wlc_pkg::IRQ_W-1:0] irq_en_d;
    logic [wlc_pkg::IRQ_W-1:0] irq_evt;
    logic [wlc_pkg::IRQ_W-1:0] irq_clr;
    logic wake_prev_q;
    logic wake_prev_d;
    // Clock source state
    wlc_hf_e hf_q;
    wlc_hf_e hf_d;
    logic lf_xtal_q;
    logic lf_xtal_d;
    // Read path
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] rmux;

    // Write decode
    logic wr_level;
    logic wr_wake_en;
    logic wr_xtal;
    logic wr_dir;
    logic wr_out;
    logic wr_drive;
    logic wr_pull;
    logic wr_clr;
    logic wr_irq_en;
    logic wr_clk;

    assign wr_level = wr && addr == wlc_pkg::OFS_WAKE_LEVEL;
    assign wr_wake_en = wr && addr == wlc_pkg::OFS_WAKE_EN;
    assign wr_xtal = wr && addr == wlc_pkg::OFS_XTAL_CFG;
    assign wr_dir = wr && addr == wlc_pkg::OFS_LP_DIR;
    assign wr_out = wr && addr == wlc_pkg::OFS_LP_OUT;
    assign wr_drive = wr && addr == wlc_pkg::OFS_LP_DRIVE;
    assign wr_pull = wr && addr == wlc_pkg::OFS_LP_PULL;
    assign wr_clr = wr && addr == wlc_pkg::OFS_IRQ_CLEAR;
    assign wr_irq_en = wr && addr == wlc_pkg::OFS_IRQ_ENABLE;
    assign wr_clk = wr && addr == wlc_pkg::OFS_CLK_CTRL;

    // Configuration next values
    always_comb
    begin
        wake_level_d = wake_level_q;
        wake_src_d = wake_src_q;
        fast_xtal_d = fast_xtal_q;
        lp_dir_d = lp_dir_q;
        lp_out_d = lp_out_q;
        lp_drive_d = lp_drive_q;
        lp_pull_d = lp_pull_q;
        clk_ctrl_d = clk_ctrl_q;
        // Reserved bits are not stored, so they always read as reset value
        if (wr_level)
        begin
            wake_level_d = wdata[NW-1:0];
        end
        if (wr_wake_en)
        begin
            wake_src_d = wdata[NW-1:0];
        end
        if (wr_xtal)
        begin
            fast_xtal_d = wdata[0];
        end
        if (wr_dir)
        begin
            lp_dir_d = wdata[NL-1:0];
        end
        if (wr_out)
        begin
            // Stored regardless of direction, so reads return it
            lp_out_d = wdata[NL-1:0];
        end
        if (wr_drive)
        begin
            lp_drive_d = wdata[NL-1:0];
        end
        if (wr_pull)
        begin
            lp_pull_d = wdata[NL-1:0];
        end
        if (wr_clk)
        begin
            clk_ctrl_d = wdata[1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wake_level_q <= wlc_pkg::RST_WAKE_LEVEL;
            wake_src_q <= wlc_pkg::RST_WAKE_EN;
            fast_xtal_q <= wlc_pkg::RST_FAST_XTAL;
            lp_dir_q <= wlc_pkg::RST_LP_DIR;
            lp_out_q <= wlc_pkg::RST_LP_OUT;
            lp_drive_q <= wlc_pkg::RST_LP_DRIVE;
            lp_pull_q <= wlc_pkg::RST_LP_PULL;
            clk_ctrl_q <= wlc_pkg::RST_CLK_CTRL;
        end
        else
        begin
            wake_level_q <= wake_level_d;
            wake_src_q <= wake_src_d;
            fast_xtal_q <= fast_xtal_d;
            lp_dir_q <= lp_dir_d;
            lp_out_q <= lp_out_d;
            lp_drive_q <= lp_drive_d;
            lp_pull_q <= lp_pull_d;
            clk_ctrl_q <= clk_ctrl_d;
        end
    end

    // Clock source selection
    always_comb
    begin
        hf_d = hf_q;
        unique case (hf_q)
            HF_RING:
            begin
                if (clk_ctrl_q[wlc_pkg::CLK_XO_REQ])
                begin
                    hf_d = HF_START;
                end
            end
            HF_START:
            begin
                // Ring oscillator stays selected until the crystal settles
                if (!clk_ctrl_q[wlc_pkg::CLK_XO_REQ])
                begin
                    hf_d = HF_RING;
                end
                else if (xo_ready)
                begin
                    hf_d = HF_XO;
                end
            end
            HF_XO:
            begin
                if (!clk_ctrl_q[wlc_pkg::CLK_XO_REQ] || !xo_ready)
                begin
                    hf_d = HF_RING;
                end
            end
        endcase
        // Crystal used only when asked for and reported good
        lf_xtal_d = clk_ctrl_q[wlc_pkg::CLK_LF_XTAL] & lf_xtal_ok;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hf_q <= HF_RING;
            lf_xtal_q <= 1'b0;
        end
        else
        begin
            hf_q <= hf_d;
            lf_xtal_q <= lf_xtal_d;
        end
    end

    // Interrupt status: set wins over clear
    always_comb
    begin
        irq_evt = '0;
        irq_evt[wlc_pkg::IRQ_WAKE] = cfg.wake_req & ~wake_prev_q;
        irq_evt[wlc_pkg::IRQ_XO_READY] = hf_q == HF_START && hf_d == HF_XO;
        irq_evt[wlc_pkg::IRQ_XO_LOST] = hf_q == HF_XO && !xo_ready;
        irq_clr = wr_clr ? wdata[wlc_pkg::IRQ_W-1:0] : '0;
        irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
        irq_en_d = wr_irq_en ? wdata[wlc_pkg::IRQ_W-1:0] : irq_en_q;
        wake_prev_d = cfg.wake_req;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_stat_q <= '0;
            irq_en_q <= '0;
            wake_prev_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            irq_en_q <= irq_en_d;
            wake_prev_q <= wake_prev_d;
        end
    end

    // Read mux; unmapped and write-only offsets read zero
    always_comb
    begin
        rmux = '0;
        unique case (addr)
            wlc_pkg::OFS_WAKE_LEVEL: rmux[NW-1:0] = wake_level_q;
            wlc_pkg::OFS_WAKE_EN: rmux[NW-1:0] = wake_src_q;
            wlc_pkg::OFS_XTAL_CFG: rmux[0] = fast_xtal_q;
            wlc_pkg::OFS_LP_DIR: rmux[NL-1:0] = lp_dir_q;
            wlc_pkg::OFS_LP_OUT: rmux[NL-1:0] = lp_out_q;
            wlc_pkg::OFS_LP_DRIVE: rmux[NL-1:0] = lp_drive_q;
            wlc_pkg::OFS_LP_PULL: rmux[NL-1:0] = lp_pull_q;
            wlc_pkg::OFS_IRQ_STATUS: rmux[wlc_pkg::IRQ_W-1:0] = irq_stat_q;
            wlc_pkg::OFS_IRQ_ENABLE: rmux[wlc_pkg::IRQ_W-1:0] = irq_en_q;
            wlc_pkg::OFS_CLK_CTRL: rmux[1:0] = clk_ctrl_q;
            wlc_pkg::OFS_CLK_STATUS:
            begin
                rmux[wlc_pkg::CST_HF_XO] = hf_q == HF_XO;
                rmux[wlc_pkg::CST_LF_XTAL] = lf_xtal_q;
                rmux[wlc_pkg::CST_LP_MODE] = lp_mode;
                rmux[wlc_pkg::CST_WAKE_REQ] = cfg.wake_req;
                rmux[wlc_pkg::CST_XO_START] = hf_q == HF_START;
            end
            default: rmux = '0;
        endcase
        rdata_d = rd ? rmux : '0;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // Submodule connections
    assign cfg.lp_mode = lp_mode;
    assign cfg.wake_level = wake_level_q;
    assign cfg.wake_en = wake_src_q;
    assign cfg.wake_pins = wake_pins;
    assign cfg.lp_dir = lp_dir_q;
    assign cfg.lp_out = lp_out_q;

    wlc_wake_detect #(.NW(NW)) u_wake (
        .cfg(cfg.wake)
    );

    wlc_lp_pad #(.NL(NL)) u_pad (
        .cfg(cfg.pad)
    );

    // Outputs
    assign rdata = rdata_q;
    assign wake_req = cfg.wake_req;
    assign lp_pin_o = cfg.pin_o;
    assign lp_pin_oe = cfg.pin_oe;
    assign lp_drive_hi = lp_drive_q;
    // Pull stays live even on wake source pins
    assign lp_pull_en = lp_pull_q;
    assign xo_enable = hf_q != HF_RING;
    assign hf_sel_xo = hf_q == HF_XO;
    assign lf_sel_xtal = lf_xtal_q;
    assign fast_crystal_flag = fast_xtal_q;
    assign irq = |(irq_stat_q & irq_en_q);
endmodule : wlc_ctrl
`default_nettype wire

// ---- verif/wlc_ctrl_chk.sv ----
// Port checker of the wake and low-power pin bank.
// Assumes writes land at the edge that takes the write strobe.
`default_nettype none
module wlc_ctrl_chk #(
    parameter int NW = 5,
    parameter int NL = 3
) (
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic rst,
    input wire logic [wlc_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Pins and clocks
    input wire logic lp_mode,
    input wire logic wake_req,
    input wire logic [NW-1:0] wake_pins,
    input wire logic [NL-1:0] lp_pin_o,
    input wire logic [NL-1:0] lp_pin_oe,
    input wire logic [NL-1:0] lp_drive_hi,
    input wire logic [NL-1:0] lp_pull_en,
    input wire logic xo_ready,
    input wire logic hf_sel_xo,
    input wire logic fast_crystal_flag,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NW-1:0] lvl_q, lvl_d, en_q, en_d;
    logic [NL-1:0] dir_q, dir_d, out_q, out_d, drv_q, drv_d, pul_q, pul_d;
    logic fx_q, fx_d;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Shadow copy of the writable pin and crystal-flag fields, from the strobes alone
    always_comb
    begin
        {lvl_d, en_d, dir_d, out_d, drv_d, pul_d, fx_d} =
            {lvl_q, en_q, dir_q, out_q, drv_q, pul_q, fx_q};
        if (wr)
        begin
            case (addr)
                wlc_pkg::OFS_WAKE_LEVEL: lvl_d = wdata[NW-1:0];
                wlc_pkg::OFS_WAKE_EN: en_d = wdata[NW-1:0];
                wlc_pkg::OFS_XTAL_CFG: fx_d = wdata[0];
                wlc_pkg::OFS_LP_DIR: dir_d = wdata[NL-1:0];
                wlc_pkg::OFS_LP_OUT: out_d = wdata[NL-1:0];
                wlc_pkg::OFS_LP_DRIVE: drv_d = wdata[NL-1:0];
                wlc_pkg::OFS_LP_PULL: pul_d = wdata[NL-1:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            lvl_q <= NW'(wlc_pkg::RST_WAKE_LEVEL);
            en_q <= NW'(wlc_pkg::RST_WAKE_EN);
            dir_q <= NL'(wlc_pkg::RST_LP_DIR);
            out_q <= NL'(wlc_pkg::RST_LP_OUT);
            drv_q <= NL'(wlc_pkg::RST_LP_DRIVE);
            pul_q <= NL'(wlc_pkg::RST_LP_PULL);
            fx_q <= wlc_pkg::RST_FAST_XTAL;
        end
        else
        begin
            {lvl_q, en_q, dir_q, out_q, drv_q, pul_q, fx_q} <=
                {lvl_d, en_d, dir_d, out_d, drv_d, pul_d, fx_d};
        end
    end
    a_wake_calc: assert property (
        wake_req == (lp_mode && |(en_q & ~(wake_pins ^ lvl_q))))
        else $error("wake request differs from level and enable");
    a_oe_calc: assert property (
        lp_pin_oe == ({NL{lp_mode}} & ~dir_q & ~en_q[NL-1:0]))
        else $error("output enable differs from direction");
    a_out_gate: assert property (lp_pin_o == (out_q & lp_pin_oe))
        else $error("pin output differs from written value");
    a_drive_map: assert property (lp_drive_hi == drv_q)
        else $error("drive strength differs");
    a_pull_map: assert property (lp_pull_en == pul_q)
        else $error("pull enable differs");
    a_xtal_flag: assert property (fast_crystal_flag == fx_q)
        else $error("crystal flag differs");
    a_out_read: assert property (
        rd && addr == wlc_pkg::OFS_LP_OUT |=> rdata == 32'($past(out_q)))
        else $error("output value read back wrong");
    a_en_read: assert property (
        rd && addr == wlc_pkg::OFS_WAKE_EN |=> rdata == 32'($past(en_q)))
        else $error("wake enable read back wrong");
    a_ring_start: assert property (!$past(xo_ready) |-> !hf_sel_xo)
        else $error("fast clock on crystal before it is ready");
    c_wake: cover property ($rose(wake_req));
    c_xo: cover property ($rose(hf_sel_xo));
    c_oe: cover property (|lp_pin_oe);
    c_irq: cover property ($rose(irq));
endmodule : wlc_ctrl_chk
`default_nettype wire

// ---- verif/wlc_far_side.sv ----
// Far-side model: drivers of the wake pins and the fast crystal.
// Assumes the bench commands pin levels; the crystal settles slowly.
`default_nettype none
module wlc_far_side #(
    parameter int XO_LAG = 6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Commands and crystal request
    input wire logic [4:0] pin_cmd,
    input wire logic [4:0] pin_drv,
    input wire logic xo_enable,
    // Pins seen by the block
    output logic [4:0] wake_pins,
    output logic xo_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    logic tog;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            tog <= 1'b0;
        end
        else
        begin
            tog <= ~tog;
            cnt <= xo_enable ? ((cnt < XO_LAG) ? cnt + 1 : cnt) : 0;
        end
    end
    // Released pins: first three pulled up, the rest float
    always_comb
    begin
        for (int i = 0; i < 5; i++)
            wake_pins[i] = pin_drv[i] ? pin_cmd[i] : ((i < 3) ? 1'b1 : tog);
    end
    assign xo_ready = (cnt == XO_LAG);
endmodule : wlc_far_side
`default_nettype wire

// ---- verif/wlc_ctrl_tb_top.sv ----
// Self-checking bench of the wake and low-power pin bank.
// Assumes the package, design, checker and far-side model come first.
`default_nettype none
module wlc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic lp_mode = 1'b0;
    logic lf_ok = 1'b0;
    logic [4:0] pin_cmd = 5'h1f;
    logic [31:0] rdata;
    logic [4:0] pins;
    logic [2:0] pin_o, pin_oe, drv_hi, pull_en;
    logic wake_req, xo_ready, xo_en, hf_xo, lf_xt, fx, irq;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] ofs [7] = '{wlc_pkg::OFS_WAKE_LEVEL, wlc_pkg::OFS_WAKE_EN,
        wlc_pkg::OFS_XTAL_CFG, wlc_pkg::OFS_LP_DIR, wlc_pkg::OFS_LP_OUT,
        wlc_pkg::OFS_LP_DRIVE, wlc_pkg::OFS_LP_PULL};
    logic [31:0] rv [7] = '{32'h0, 32'h7, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0};
    logic [31:0] msk [7] = '{32'h1f, 32'h1f, 32'h1, 32'h7, 32'h7, 32'h7, 32'h7};
    always #50 mclk = ~mclk;
    wlc_ctrl dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .lp_mode(lp_mode), .wake_req(wake_req), .wake_pins(pins),
        .lp_pin_o(pin_o), .lp_pin_oe(pin_oe), .lp_drive_hi(drv_hi), .lp_pull_en(pull_en),
        .xo_ready(xo_ready), .lf_xtal_ok(lf_ok), .xo_enable(xo_en), .hf_sel_xo(hf_xo),
        .lf_sel_xtal(lf_xt), .fast_crystal_flag(fx), .irq(irq));
    wlc_far_side far (.mclk(mclk), .rst(rst), .pin_cmd(pin_cmd), .pin_drv(5'h1f),
        .xo_enable(xo_en), .wake_pins(pins), .xo_ready(xo_ready));
    task automatic test_done();
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    // Hang guard, well above the length of the sequence
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            test_done();
        end
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 cmp("rdata", e, rdata);
    endtask : chk_reg
    function automatic logic exp_wake(input logic [4:0] l, input logic [4:0] e,
        input logic [4:0] p);
        return |(e & ~(p ^ l));
    endfunction : exp_wake
    initial
    begin
        logic [31:0] v, l, e, dr, o;
        logic xw;
        v = $urandom(39606);
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++)
            chk_reg(ofs[i], rv[i]);
        for (int i = 0; i < 7; i++)
        begin
            v = $urandom() & msk[i];
            wr_reg(ofs[i], v);
            chk_reg(ofs[i], v);
        end
        // Unmapped place: write ignored, reads zero
        wr_reg(8'h3c, 32'h0);
        chk_reg(8'h3c, 32'h0);
        lp_mode <= 1'b1;
        for (int k = 0; k < 24; k++)
        begin
            l = $urandom() & 32'h1f;
            e = $urandom() & 32'h1f;
            dr = $urandom() & 32'h7;
            o = $urandom() & 32'h7;
            wr_reg(wlc_pkg::OFS_WAKE_LEVEL, l);
            wr_reg(wlc_pkg::OFS_WAKE_EN, e);
            wr_reg(wlc_pkg::OFS_LP_DIR, dr);
            wr_reg(wlc_pkg::OFS_LP_OUT, o);
            wr_reg(wlc_pkg::OFS_LP_DRIVE, o ^ 32'h5);
            wr_reg(wlc_pkg::OFS_LP_PULL, dr);
            pin_cmd <= 5'($urandom());
            @(posedge mclk);
            #1 xw = exp_wake(l[4:0], e[4:0], pin_cmd);
            cmp("wake_req", 32'(xw), 32'(wake_req));
            cmp("pin_oe", {29'h0, ~dr[2:0] & ~e[2:0]}, 32'(pin_oe));
            cmp("pin_o", 32'(o[2:0] & ~dr[2:0] & ~e[2:0]), 32'(pin_o));
            cmp("drive", o ^ 32'h5, 32'(drv_hi));
            cmp("pull", dr, 32'(pull_en));
            chk_reg(wlc_pkg::OFS_LP_OUT, o);
        end
        // Wake interrupt: raise, mask, clear
        pin_cmd <= 5'h00;
        wr_reg(wlc_pkg::OFS_WAKE_LEVEL, 32'h1);
        wr_reg(wlc_pkg::OFS_WAKE_EN, 32'h1);
        wr_reg(wlc_pkg::OFS_IRQ_CLEAR, 32'h7);
        wr_reg(wlc_pkg::OFS_IRQ_ENABLE, 32'h1);
        #1 cmp("irq", 32'h0, 32'(irq));
        pin_cmd <= 5'h01;
        repeat (3) @(posedge mclk);
        #1 cmp("irq", 32'h1, 32'(irq));
        chk_reg(wlc_pkg::OFS_IRQ_STATUS, 32'h1);
        wr_reg(wlc_pkg::OFS_IRQ_ENABLE, 32'h0);
        #1 cmp("irq", 32'h0, 32'(irq));
        wr_reg(wlc_pkg::OFS_IRQ_CLEAR, 32'h1);
        chk_reg(wlc_pkg::OFS_IRQ_STATUS, 32'h0);
        lp_mode <= 1'b0;
        @(posedge mclk);
        #1 cmp("wake_off", 32'h0, 32'(wake_req));
        cmp("oe_off", 32'h0, 32'(pin_oe));
        // Crystal start: ring clock stays until the crystal settles
        wr_reg(wlc_pkg::OFS_XTAL_CFG, 32'h1);
        #1 cmp("xtal_flag", 32'h1, 32'(fx));
        lf_ok <= 1'b1;
        wr_reg(wlc_pkg::OFS_CLK_CTRL, 32'h3);
        // Start state is entered one cycle after the request lands
        #1 cmp("xo_idle", 32'h0, 32'(xo_en));
        @(posedge mclk);
        #1 cmp("xo_en", 32'h1, 32'(xo_en));
        // Far-side crystal needs six enabled cycles, then one more to switch
        repeat (6)
        begin
            @(posedge mclk);
            #1 cmp("hf_start", 32'h0, 32'(hf_xo));
        end
        @(posedge mclk);
        #1 cmp("hf_xo", 32'h1, 32'(hf_xo));
        cmp("lf_xtal", 32'h1, 32'(lf_xt));
        chk_reg(wlc_pkg::OFS_CLK_STATUS, 32'h3);
        chk_reg(wlc_pkg::OFS_IRQ_STATUS, 32'h2);
        wr_reg(wlc_pkg::OFS_CLK_CTRL, 32'h0);
        @(posedge mclk);
        #1 cmp("hf_ring", 32'h0, 32'(hf_xo));
        test_done();
    end
endmodule : wlc_ctrl_tb_top
bind wlc_ctrl wlc_ctrl_chk #(.NW(NW), .NL(NL)) u_chk (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lp_mode(lp_mode), .wake_req(wake_req),
    .wake_pins(wake_pins), .lp_pin_o(lp_pin_o), .lp_pin_oe(lp_pin_oe),
    .lp_drive_hi(lp_drive_hi), .lp_pull_en(lp_pull_en), .xo_ready(xo_ready),
    .hf_sel_xo(hf_sel_xo), .fast_crystal_flag(fast_crystal_flag), .irq(irq));
`default_nettype wire
